/* File: hdl/tsc_consts.svh */
// tsc_consts.svh: timing counts, field positions and codes of the touch converter serial link
// assumes: included by the package and by the bench; holds definitions only
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// control word field positions
`define TSC_BIT_START 7
`define TSC_CH_HI 6
`define TSC_CH_LO 4
`define TSC_BIT_MODE 3
`define TSC_BIT_REF 2
`define TSC_PD_HI 1
`define TSC_PD_LO 0
// power-down codes
`define TSC_PD_AUTO_PEN 2'h0
`define TSC_PD_AUTO 2'h1
`define TSC_PD_RSVD 2'h2
`define TSC_PD_ON 2'h3
// frame counts in serial clocks
`define TSC_WORD_BITS 4'h8
`define TSC_ACQ_AT 4'h5
`define TSC_RES12 4'hc
`define TSC_RES8 4'h8
`define TSC_FRAME_CLKS 5'h18
// apb register offsets of the host controller
`define TSC_REG_CTRL 12'h000
`define TSC_REG_STAT 12'h004
`define TSC_REG_DATA 12'h008
`define TSC_REG_DIV 12'h00c
// status bits
`define TSC_ST_BUSY 0
`define TSC_ST_DONE 1
// default half period of the generated serial clock, pclk cycles
`define TSC_DIV_RST 8'h10

`endif

/* File: hdl/tsc_pkg.sv */
// tsc_pkg.sv: shared types of the touch converter serial link
// assumes: tsc_consts.svh on the include path
`include "tsc_consts.svh"

package tsc_pkg;
    // one-hot device phase
    typedef enum logic [3:0] {
        TSC_IDLE = 4'h1,
        TSC_WORD = 4'h2,
        TSC_CONV = 4'h4,
        TSC_TAIL = 4'h8
    } tsc_phase_t;
    // one-hot host phase
    typedef enum logic [2:0] {
        TSC_H_IDLE = 3'h1,
        TSC_H_RUN = 3'h2,
        TSC_H_END = 3'h4
    } tsc_hphase_t;
endpackage : tsc_pkg

/* File: hdl/tsc_link_if.sv */
// tsc_link_if.sv: serial pins between host controller and touch converter
// assumes: the bench ties both ends' clock and checks high impedance via the enables
`timescale 1ns/1ps

interface tsc_link_if;
    logic serial_clock_in; // serial clock from host
    logic cs_n; // chip select, active low
    logic din; // control bits to device
    logic dout; // result bits from device
    logic dout_oe; // device drives dout
    logic busy; // conversion busy
    logic busy_oe; // device drives busy
    modport dev (input serial_clock_in, input cs_n, input din, output dout, output dout_oe,
                 output busy, output busy_oe);
    modport host (output serial_clock_in, output cs_n, output din, input dout, input dout_oe,
                  input busy, input busy_oe);
endinterface : tsc_link_if

/* File: hdl/tsc_device.sv */
// tsc_device.sv: device end, control word capture and conversion sequencing
// assumes: link pins arrive asynchronously to pclk and are synchronised here; the analog
// result arrives on sample_code, captured at hold
//
// Function
// RULE_01: conversion frame is three eight-clock transfers
// RULE_02: host sends control word msb first
// RULE_03: acquire after mux bits, hold after word
// RULE_04: twelve conversion clocks, thirteenth bit, trailing lows
// RULE_05: ratiometric keeps switches on during conversion
// RULE_06: ignore input until high start bit
// RULE_07: decode start, channel, mode, reference, power-down
// RULE_08: mode bit low twelve, high eight
// RULE_09: reference bit high single-ended, low differential
// RULE_10: new word every 15th or 11th clock
// RULE_11: code 00 power-down, pen on, corner on
// RULE_12: code 01 power-down, pen off, corner off
// RULE_13: host never programs reserved code 10
// RULE_14: code 11 always powered, pen off
// RULE_15: wake instantly at conversion start
// RULE_16: next word overlaps result, sixteen clocks
// RULE_17: host finishes conversion within 1.6 ms
// RULE_18: stay powered while conversion suspended
// RULE_19: sample rising edge, update after falling
// RULE_20: chip select high floats outputs, ignores clock
// RULE_21: result is straight binary
// RULE_22: result msb first after word
// RULE_23: eight-bit mode ends four clocks earlier
`timescale 1ns/1ps

module tsc_device
    import tsc_pkg::*;
#(
    parameter int RES_W = 12 // converter resolution
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // link
    tsc_link_if.dev link,
    // analog side
    input wire logic [RES_W-1:0] sample_code,
    output logic [2:0] channel_select,
    output logic reference_mode_select,
    output logic switches_on,
    output logic lower_right_switch,
    output logic pen_enable,
    output logic powered,
    output logic sample_hold,
    output logic [7:0] conversion_control_word
);

    // whole state of the end
    typedef struct packed {
        logic [1:0] sck_s; // serial clock synchroniser
        logic sck_d; // last synchronised clock
        logic [1:0] cs_s; // chip select synchroniser
        logic [1:0] din_s; // data synchroniser
        tsc_phase_t ph; // phase
        logic [3:0] cnt; // clocks in current phase
        logic [7:0] sh; // incoming word shift
        logic [7:0] word; // active control word
        logic [RES_W-1:0] res; // result shift
        logic [3:0] nbits; // result bits left
        logic dout; // serial output
        logic dout_oe;
        logic busy;
        logic busy_oe;
        logic sw; // panel switches
        logic hold; // sample held
        logic pwr; // analog powered
        logic lr; // corner switch
        logic pen; // pen interrupt enabled
    } tsc_dev_t;

    tsc_dev_t s;
    tsc_dev_t next_s;

    logic rise; // rising serial clock seen
    logic fall; // falling serial clock seen
    logic sel; // chip selected
    logic bit_in; // sampled serial input
    logic [7:0] w; // word as completed this clock

    // next-state logic
    always_comb begin
        next_s = s;
        next_s.sck_s = {s.sck_s[0], link.serial_clock_in};
        next_s.cs_s = {s.cs_s[0], link.cs_n};
        next_s.din_s = {s.din_s[0], link.din};
        next_s.sck_d = s.sck_s[1];
        sel = ~s.cs_s[1];
        rise = sel & s.sck_s[1] & ~s.sck_d; // RULE_20
        fall = sel & ~s.sck_s[1] & s.sck_d;
        bit_in = s.din_s[1];
        w = {s.sh[6:0], bit_in};
        // chip select gates the pins
        next_s.dout_oe = sel; // RULE_20
        next_s.busy_oe = sel;
        if (rise) begin
            // sample input on rising edge
            case (s.ph)
                TSC_WORD: begin
                    next_s.sh = w; // RULE_02
                    next_s.cnt = s.cnt + 4'h1;
                    if (s.cnt + 4'h1 == `TSC_ACQ_AT) begin
                        // mux bits known: acquire
                        next_s.hold = 1'b0; // RULE_03
                        next_s.sw = 1'b1;
                        next_s.pwr = 1'b1; // RULE_15
                        next_s.word[`TSC_BIT_START:`TSC_BIT_MODE] = w[4:0];
                    end
                    if (s.cnt + 4'h1 == `TSC_WORD_BITS) begin
                        // word complete: hold and convert
                        next_s.word = w; // RULE_07
                        next_s.hold = 1'b1; // RULE_03
                        next_s.sw = ~w[`TSC_BIT_REF]; // RULE_05 RULE_09
                        next_s.res = sample_code; // RULE_21
                        next_s.nbits = w[`TSC_BIT_MODE] ? `TSC_RES8 : `TSC_RES12; // RULE_08 RULE_23
                        next_s.ph = TSC_CONV;
                        next_s.cnt = 4'h0;
                    end
                end
                TSC_CONV, TSC_TAIL, TSC_IDLE: begin
                    // a high bit here starts the next word
                    if (bit_in) begin // RULE_06 RULE_10 RULE_16
                        next_s.ph = TSC_WORD;
                        next_s.sh = 8'h01;
                        next_s.cnt = 4'h1;
                    end
                end
                default: next_s.ph = TSC_IDLE;
            endcase
        end
        if (fall) begin
            // update output after falling edge
            if (s.ph == TSC_CONV && s.cnt == 4'h0) begin
                // busy for the clock after the word; the msb follows on the next fall
                next_s.busy = 1'b1;
                next_s.cnt = 4'h1;
                next_s.dout = 1'b0; // RULE_04
            end else if (s.nbits != 4'h0) begin
                next_s.dout = s.res[RES_W-1]; // RULE_19 RULE_22
                next_s.res = {s.res[RES_W-2:0], 1'b0};
                next_s.nbits = s.nbits - 4'h1;
                next_s.busy = 1'b0;
            end else begin
                next_s.dout = 1'b0; // RULE_04
                if (s.hold) begin
                    // conversion done, apply power-down code
                    next_s.hold = 1'b0;
                    next_s.sw = 1'b0;
                    case (s.word[`TSC_PD_HI:`TSC_PD_LO])
                        `TSC_PD_AUTO_PEN: begin
                            next_s.pwr = 1'b0; // RULE_11
                            next_s.lr = 1'b1;
                            next_s.pen = 1'b1;
                        end
                        `TSC_PD_AUTO: begin
                            next_s.pwr = 1'b0; // RULE_12
                            next_s.lr = 1'b0;
                            next_s.pen = 1'b0;
                        end
                        default: begin
                            next_s.pwr = 1'b1; // RULE_14
                            next_s.lr = 1'b0;
                            next_s.pen = 1'b0;
                        end
                    endcase
                end
            end
        end
        if (s.ph == TSC_CONV && s.nbits == 4'h0 && s.cnt != 4'h0) begin
            next_s.ph = TSC_TAIL; // RULE_01
        end
        // powered stays on while suspended mid conversion
        if (next_s.hold) begin
            next_s.pwr = 1'b1; // RULE_18
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{sck_s: 2'h0, sck_d: 1'b0, cs_s: 2'h3, din_s: 2'h0, ph: TSC_IDLE, cnt: 4'h0,
                   sh: 8'h00, word: 8'h00, res: '0, nbits: 4'h0, dout: 1'b0, dout_oe: 1'b0,
                   busy: 1'b0, busy_oe: 1'b0, sw: 1'b0, hold: 1'b0, pwr: 1'b0, lr: 1'b1,
                   pen: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // pin and analog outputs, all from flops
    assign link.dout = s.dout;
    assign link.dout_oe = s.dout_oe;
    assign link.busy = s.busy;
    assign link.busy_oe = s.busy_oe;
    assign channel_select = s.word[`TSC_CH_HI:`TSC_CH_LO];
    assign reference_mode_select = s.word[`TSC_BIT_REF];
    assign switches_on = s.sw;
    assign lower_right_switch = s.lr;
    assign pen_enable = s.pen;
    assign powered = s.pwr;
    assign sample_hold = s.hold;
    assign conversion_control_word = s.word;

endmodule : tsc_device

/* File: hdl/tsc_host.sv */
// tsc_host.sv: host end, apb-programmed 24-clock conversion frame
// assumes: apb master on pclk; the device end meets it through tsc_link_if
`timescale 1ns/1ps

module tsc_host
    import tsc_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    tsc_link_if.host link
);

    // whole state of the end
    typedef struct packed {
        tsc_hphase_t ph;
        logic [7:0] word; // control word to send
        logic [7:0] div; // half period in pclk cycles
        logic [7:0] dcnt; // divider count
        logic [4:0] ncl; // serial clocks issued
        logic [23:0] sh; // outgoing bits
        logic [15:0] rx; // received bits
        logic [11:0] result; // last result
        logic done; // result ready, sticky
        logic [1:0] do_s; // dout synchroniser
        logic sck;
        logic cs_n;
        logic din;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tsc_host_t;

    tsc_host_t s;
    tsc_host_t next_s;
    logic acc; // apb access phase
    logic go; // start request
    logic wr; // apb write completes at this edge

    // next-state logic
    always_comb begin
        next_s = s;
        acc = psel & penable & ~s.pready;
        go = 1'b0;
        wr = psel & penable & pwrite & s.pready;
        next_s.pready = acc;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0;
        next_s.do_s = {s.do_s[0], link.dout};
        if (acc || wr) begin
            // register decode; reads answer at the access edge, writes land when the transfer completes
            case (paddr)
                `TSC_REG_CTRL: begin
                    next_s.prdata = {24'h0, s.word};
                    // a word written during a frame is dropped so the running frame keeps its mode
                    if (wr && s.ph == TSC_H_IDLE) begin
                        next_s.word = pwdata[7:0];
                        go = 1'b1;
                    end
                end
                `TSC_REG_STAT: begin
                    next_s.prdata = {30'h0, s.done, s.ph != TSC_H_IDLE};
                    if (wr && pwdata[`TSC_ST_DONE]) begin
                        next_s.done = 1'b0;
                    end
                end
                `TSC_REG_DATA: next_s.prdata = {20'h0, s.result};
                `TSC_REG_DIV: begin
                    next_s.prdata = {24'h0, s.div};
                    if (wr) begin
                        next_s.div = (pwdata[7:0] == 8'h0) ? 8'h01 : pwdata[7:0];
                    end
                end
                default: next_s.pslverr = acc;
            endcase
        end
        case (s.ph)
            TSC_H_IDLE: begin
                if (go) begin
                    // start frame: word then 16 zeros
                    next_s.ph = TSC_H_RUN;
                    next_s.cs_n = 1'b0;
                    next_s.sh = {pwdata[7:0], 16'h0};
                    next_s.din = pwdata[7]; // RULE_02
                    next_s.ncl = 5'h0;
                    next_s.dcnt = s.div;
                end
            end
            TSC_H_RUN: begin
                if (s.dcnt > 8'h1) begin
                    next_s.dcnt = s.dcnt - 8'h1;
                end else begin
                    next_s.dcnt = s.div;
                    next_s.sck = ~s.sck; // RULE_17
                    if (s.sck) begin
                        // falling edge: next bit out
                        next_s.sh = {s.sh[22:0], 1'b0};
                        next_s.din = s.sh[22]; // RULE_19
                        next_s.ncl = s.ncl + 5'h1;
                        if (s.ncl + 5'h1 == `TSC_FRAME_CLKS) begin // RULE_01
                            next_s.ph = TSC_H_END;
                        end
                    end else if (s.ncl >= 5'h8) begin
                        // rising edge: capture result bit
                        next_s.rx = {s.rx[14:0], s.do_s[1]};
                    end
                end
            end
            TSC_H_END: begin
                next_s.cs_n = 1'b1;
                next_s.result = s.word[`TSC_BIT_MODE] ? {4'h0, s.rx[14:7]} : s.rx[14:3];
                next_s.done = 1'b1;
                next_s.ph = TSC_H_IDLE;
            end
            default: next_s.ph = TSC_H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{ph: TSC_H_IDLE, word: 8'h00, div: `TSC_DIV_RST, dcnt: 8'h00, ncl: 5'h0,
                   sh: 24'h0, rx: 16'h0, result: 12'h000, done: 1'b0, do_s: 2'h0, sck: 1'b0,
                   cs_n: 1'b1, din: 1'b0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // outputs from flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign link.serial_clock_in = s.sck;
    assign link.cs_n = s.cs_n;
    assign link.din = s.din;

endmodule : tsc_host

/* File: tb/tsc_link_asserts.sv */
// tsc_link_asserts.sv: concurrent checks on the serial link between host and device ends
// assumes: instantiated beside tsc_link_if in the bench; every signal sampled on pclk
`timescale 1ns/1ps

module tsc_link_asserts (
    // system
    input logic pclk,
    input logic presetn,
    // link
    input logic serial_clock_in,
    input logic cs_n,
    input logic din,
    input logic dout,
    input logic dout_oe,
    input logic busy,
    input logic busy_oe
);
    logic sck_q; // serial clock one pclk ago
    logic [5:0] rises; // serial clock rises seen in this frame

    // count rising serial clock edges while the device is selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            rises <= 6'h0;
        end else begin
            sck_q <= serial_clock_in;
            if (cs_n) begin
                rises <= 6'h0;
            end else if (serial_clock_in && !sck_q) begin
                rises <= rises + 6'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_frame_count: assert property ($rose(cs_n) |-> rises == 6'h18)
        else $error("frame did not carry 24 serial clocks");
    a_float_idle: assert property (cs_n [*4] |-> !dout_oe && !busy_oe)
        else $error("outputs still driven while deselected");
    a_enable_select: assert property ($fell(cs_n) |-> ##[1:6] (dout_oe && busy_oe))
        else $error("outputs not enabled after select");
    a_trail_low: assert property (!cs_n && dout_oe && rises >= 6'h16 |-> !dout)
        else $error("serial output high in trailing clocks");
    a_word_quiet: assert property (!cs_n && dout_oe && rises inside {[6'h1:6'h7]} |-> !dout)
        else $error("result bits before control word complete");
    a_busy_late: assert property (!cs_n && busy_oe && rises <= 6'h7 |-> !busy)
        else $error("busy raised during control word");
    a_din_steady: assert property (!cs_n && serial_clock_in && $past(serial_clock_in) |-> $stable(din))
        else $error("serial input changed while clock high");
    a_dout_on_low: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !serial_clock_in)
        else $error("serial output changed while clock high");
endmodule : tsc_link_asserts

/* File: tb/touch_adc_serial_control_tb.sv */
// touch_adc_serial_control_tb.sv: apb-driven frames across both link ends, self-checking
// assumes: host and device meet in tsc_link_if; the checker watches that link
`timescale 1ns/1ps
`include "tsc_consts.svh"

module touch_adc_serial_control_tb;
    logic pclk; // bench clock, 200 MHz
    logic presetn; // async reset, active low
    logic psel, penable, pwrite, pready, pslverr; // apb control
    logic [11:0] paddr; // apb address
    logic [31:0] pwdata, prdata; // apb data
    logic [11:0] sample_code; // analog stand-in
    logic [2:0] channel_select; // decoded channel
    logic reference_mode_select, switches_on, lower_right_switch, pen_enable, powered, sample_hold;
    logic [7:0] conversion_control_word; // captured word
    logic [31:0] q; // last read data
    logic e; // last slave error
    logic [7:0] w; // word of this frame
    logic [1:0] pd; // power-down code of this frame
    logic [2:0] chs [4] = '{3'h1, 3'h5, 3'h2, 3'h6}; // legal channels
    integer seed; // random seed
    int err_count, compares, n;

    tsc_link_if link ();
    tsc_device #(.RES_W(12)) tsc_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .sample_code(sample_code), .channel_select(channel_select), .reference_mode_select(reference_mode_select),
        .switches_on(switches_on), .lower_right_switch(lower_right_switch), .pen_enable(pen_enable),
        .powered(powered), .sample_hold(sample_hold), .conversion_control_word(conversion_control_word));
    tsc_host tsc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    tsc_link_asserts tsc_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .serial_clock_in(link.serial_clock_in), .cs_n(link.cs_n), .din(link.din), .dout(link.dout),
        .dout_oe(link.dout_oe), .busy(link.busy), .busy_oe(link.busy_oe));

    // free-running clock
    always #2.5 pclk = ~pclk;

    // verdict and end of run
    task automatic results;
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // compare a word
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // compare a single bit
    task automatic chkb(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask : chkb

    // a wait that ran out ends the run
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            err_count++;
            results();
        end
    endtask : tmo

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        tmo(pready);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // expected result: eight-bit mode returns the top eight bits in the low byte
    function automatic logic [31:0] exp_result(input logic [7:0] wd, input logic [11:0] c);
        exp_result = wd[3] ? {24'h0, c[11:4]} : {20'h0, c};
    endfunction : exp_result

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_code = 12'h000;
        seed = 32'h0eab;
        err_count = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // unmapped address answers with an error
        apb(1'b0, 12'h010, 32'h0);
        chkb("unmapped error", 1'b1, e);
        // power-down codes 00, 01 and 11 with every mode and reference, corners first
        for (int i = 0; i < 12; i++) begin
            pd = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
            w = {1'b1, chs[$unsigned($random(seed)) % 4], 1'(i / 3 % 2), 1'(i / 6), pd};
            sample_code <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
            apb(1'b1, `TSC_REG_DIV, 32'h6 + 32'($unsigned($random(seed)) % 4));
            apb(1'b1, `TSC_REG_CTRL, {24'h0, w});
            n = 0;
            while (link.busy !== 1'b1 && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            tmo(link.busy);
            chkb("powered in conversion", 1'b1, powered);
            chkb("sample held", 1'b1, sample_hold);
            if (!w[2]) begin
                chkb("ratiometric switches", 1'b1, switches_on);
            end
            // a second start while busy is refused
            if (i == 4) begin
                apb(1'b1, `TSC_REG_CTRL, 32'hf3);
            end
            n = 0;
            do begin
                apb(1'b0, `TSC_REG_STAT, 32'h0);
                n++;
            end while (q[1] !== 1'b1 && n < 500);
            tmo(q[1]);
            chkb("no second frame", 1'b0, q[0]);
            apb(1'b0, `TSC_REG_DATA, 32'h0);
            chk("result", exp_result(w, sample_code), q);
            chk("control word", {24'h0, w}, {24'h0, conversion_control_word});
            chk("channel", {29'h0, w[6:4]}, {29'h0, channel_select});
            chkb("reference", w[2], reference_mode_select);
            chkb("pen enable", pd == 2'h0, pen_enable);
            chkb("powered idle", pd == 2'h3, powered);
            if (pd != 2'h3) begin
                chkb("corner switch", pd == 2'h0, lower_right_switch);
            end
            // clear done and see it gone
            apb(1'b1, `TSC_REG_STAT, 32'h2);
            apb(1'b0, `TSC_REG_STAT, 32'h0);
            chk("status cleared", 32'h0, q & 32'h3);
        end
        results();
    end
endmodule : touch_adc_serial_control_tb
